// file: rtl/oam_endpoint_map.vh
// Purpose: constants for the OAM endpoint engine
// Assumes: plain Verilog-2005
// Notes: timer selects index a vector of shared timer expiries
`ifndef OAM_ENDPOINT_MAP_VH
`define OAM_ENDPOINT_MAP_VH
`define MISS_MAX 3'h7
`define TLV_PORT_STATE 8'h02
`define TLV_IF_STATE 8'h04
`define TLV_END 8'h00
`define PATTERN_CRC_A 8'h01
`define PATTERN_CRC_B 8'h03
`define PDU_CCM 3'h1
`define PDU_TEST 3'h2
`define PDU_LOOP_REQ 3'h3
`define PDU_LOOP_REPLY 3'h4
`define FIFO_DEPTH 32
`define FIFO_FULL_LEVEL 6'h20
`endif

// file: rtl/cpu_copy_fifo.v
// Purpose: buffer of frame handles copied or extracted to the CPU
// Assumes: single clock, asynchronous active high reset
// Notes: depth must be a power of two
`default_nettype none
module cpu_copy_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW = 5
)(
  input wire clock,
  input wire rst,
  input wire [WIDTH-1:0] inData,
  input wire inValid,
  output wire inReady,
  output wire [WIDTH-1:0] outData,
  output wire outValid,
  input wire outReady
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wrPtr;
  reg [AW:0] rdPtr;
  wire full = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
  wire empty = (wrPtr == rdPtr);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[rdPtr[AW-1:0]];
  always @(posedge clock)
  begin
    if (inValid && !full)
      mem[wrPtr[AW-1:0]] <= inData;
  end
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wrPtr <= {(AW+1){1'b0}};
      rdPtr <= {(AW+1){1'b0}};
    end
    else
    begin
      if (inValid && !full)
        wrPtr <= wrPtr + 1'b1;
      if (outReady && !empty)
        rdPtr <= rdPtr + 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: rtl/oam_endpoint_engine.v
// Purpose: per-endpoint CCM, test and loopback PDU processing
// Assumes: pipeline presents one frame descriptor per pdu strobe
// Notes: all status and counters are plain ports
// Notes on behaviour
// (R1) Port and interface status TLVs accepted only as leading TLVs.
// (R2) Other TLV before status TLV stops parsing, flags non-zero end.
// (R3) Store status TLV values; change sets sticky and optional irq.
// (R4) Three-bit miss count increments on timer, clears on valid CCM.
// (R5) Continuity timer select picks the timer and checks Continuity_timer_select.
// (R6) Miss count at seven raises the continuity loss defect.
// (R7) Any defect change sets the continuity loss sticky flag.
// (R8) Miss count saturates instead of wrapping.
// (R9) Valid CCM during defect clears defect and sets sticky.
// (R10) Insert-next flag turns next Tx CCM into CCM-LM, then clears.
// (R11) Insert-next set by CPU or by selected LM timer expiry.
// (R12) Software keeps one of test, loopback, sequence modes active.
// (R13) Test hw disabled: statistics only, frame untouched.
// (R14) Loop request and reply have own enables; off means stats only.
// (R15) PDU and loss counting gated by their count enables.
// (R16) Tx test writes tx ID if enabled, always increments it.
// (R17) Tx loop request writes tx ID if enabled, always increments.
// (R18) Rx test: sticky, compare with rx ID plus one, store, count.
// (R19) Extract next one-shot or copy-all for Rx test and reply.
// (R20) Verify leading TEST TLV CRC, patterns 1 and 3, count fails.
// (R21) Rx loop request: sticky, inject reply if enabled, copy option.
// (R22) Count each transmitted valid loop reply.
// (R23) Rx reply: compare ID plus one, flag, count, store, still valid.
// (R24) Reply TLV check has own enable; skipped in MPLS-TP mode.
`default_nettype none
`include "oam_endpoint_map.vh"
module oam_endpoint_engine #(
  parameter CW = 32,
  parameter TW = 8,
  parameter FW = 16
)(
  input wire clock,
  input wire rst,
  input wire pduValid,
  input wire pduIsRx,
  input wire [2:0] pduType,
  input wire pduOk,
  input wire [31:0] pduSeq,
  input wire [2:0] pduPeriod,
  input wire [7:0] tlvType0,
  input wire [7:0] tlvValue0,
  input wire [7:0] tlvType1,
  input wire [7:0] tlvValue1,
  input wire [7:0] testPattern,
  input wire tlvCrcGood,
  input wire [FW-1:0] frameHandle,
  output reg pduReady,
  input wire [TW-1:0] timerExpire,
  input wire [2:0] continuity_timer_select,
  input wire [2:0] lm_insert_timer_select,
  input wire cpuSetInsertNext,
  input wire ccmHwEn,
  input wire test_pdu_hw_en,
  input wire loop_request_hw_en,
  input wire loop_reply_hw_en,
  input wire test_pdu_count_en,
  input wire test_loss_count_en,
  input wire loopCountEn,
  input wire loopLossCountEn,
  input wire test_seq_write_en,
  input wire loop_request_seq_write_en,
  input wire test_cpu_copy_en,
  input wire loop_request_cpu_copy_en,
  input wire loop_reply_cpu_copy_en,
  input wire setExtractNext,
  input wire test_tlv_check_en,
  input wire reply_tlv_check_en,
  input wire mplsTpMode,
  input wire auto_reply_en,
  input wire continuity_loss_irq_en,
  input wire port_state_irq_en,
  input wire if_state_irq_en,
  input wire clearFlags,
  output reg [2:0] continuity_miss_count,
  output reg continuity_loss_defect,
  output reg continuity_loss_flag,
  output reg lm_insert_next_flag,
  output reg [7:0] last_port_state_value,
  output reg [7:0] last_if_state_value,
  output reg port_state_change_flag,
  output reg if_state_change_flag,
  output reg endTlvFlag,
  output reg periodErrorFlag,
  output reg irq,
  output reg [31:0] tx_transaction_id,
  output reg [31:0] rx_transaction_id,
  output reg transaction_error_flag,
  output reg test_rx_flag,
  output reg loop_request_rx_flag,
  output reg loop_reply_rx_flag,
  output reg extract_next_test_frame,
  output reg [CW-1:0] reply_rx_valid_count,
  output reg [CW-1:0] sequence_error_count,
  output reg [CW-1:0] tlv_check_fail_count,
  output reg [CW-1:0] reply_tx_count,
  output reg [CW-1:0] oamTxCount,
  output reg [CW-1:0] oamRxCount,
  output reg [CW-1:0] lossTxCount,
  output reg [CW-1:0] lossRxCount,
  output reg editValid,
  output reg editSeqWrite,
  output reg [31:0] editSeq,
  output reg editLmInsert,
  output reg injectReply,
  output reg [FW-1:0] cpuHandle,
  output reg cpuValid,
  input wire cpuReady
);
  wire rxv = pduValid && pduReady && pduIsRx && pduOk;
  wire txv = pduValid && pduReady && !pduIsRx && pduOk;
  wire isCcm = (pduType == `PDU_CCM);
  wire isTest = (pduType == `PDU_TEST);
  wire isReq = (pduType == `PDU_LOOP_REQ);
  wire isRep = (pduType == `PDU_LOOP_REPLY);
  wire rxCcm = rxv && isCcm && (pduPeriod == continuity_timer_select); // R5
  wire locTick = timerExpire[continuity_timer_select]; // R5
  wire lmTick = timerExpire[lm_insert_timer_select];
  function isStatus;
    input [7:0] t;
    begin
      isStatus = (t == `TLV_PORT_STATE) || (t == `TLV_IF_STATE);
    end
  endfunction
  function [CW-1:0] bump;
    input [CW-1:0] v;
    input en;
    begin
      bump = en ? v + 1'b1 : v;
    end
  endfunction
  // Only the first two TLVs are inspected; a status TLV later is ignored
  wire lead0 = isStatus(tlvType0); // R1
  wire lead1 = lead0 && isStatus(tlvType1) && (tlvType1 != tlvType0); // R1
  wire badOrder = !lead0 && tlvType0 != `TLV_END && isStatus(tlvType1); // R2
  wire portSeen = (lead0 && tlvType0 == `TLV_PORT_STATE) ||
    (lead1 && tlvType1 == `TLV_PORT_STATE);
  wire [7:0] portVal = (tlvType0 == `TLV_PORT_STATE) ? tlvValue0 : tlvValue1;
  wire ifSeen = (lead0 && tlvType0 == `TLV_IF_STATE) ||
    (lead1 && tlvType1 == `TLV_IF_STATE);
  wire [7:0] ifVal = (tlvType0 == `TLV_IF_STATE) ? tlvValue0 : tlvValue1;
  wire seqMatch = (pduSeq == rx_transaction_id + 32'h00000001);
  wire patOk = (testPattern == `PATTERN_CRC_A) ||
    (testPattern == `PATTERN_CRC_B);
  wire tlvFail = !tlvCrcGood && patOk && (tlvType0 != `TLV_END) &&
    ((isTest && test_tlv_check_en) ||
     (isRep && reply_tlv_check_en && !mplsTpMode)); // R20 R24
  wire cntEn = isTest ? test_pdu_count_en : loopCountEn; // R15
  wire lossEn = isTest ? test_loss_count_en : loopLossCountEn; // R15
  wire seqPdu = isTest || isReq || isRep;
  wire wantCopy = rxv && ((isTest && (test_cpu_copy_en ||
    extract_next_test_frame)) || (isRep && (loop_reply_cpu_copy_en ||
    extract_next_test_frame)) || (isReq && loop_request_cpu_copy_en) ||
    (isCcm && badOrder)); // R19 R21 R2
  wire fifoInReady;
  wire [FW-1:0] fifoOut;
  wire fifoOutValid;
  cpu_copy_fifo #(.WIDTH(FW), .DEPTH(`FIFO_DEPTH), .AW(5)) copyFifo (
    .clock(clock),
    .rst(rst),
    .inData(frameHandle),
    .inValid(wantCopy),
    .inReady(fifoInReady),
    .outData(fifoOut),
    .outValid(fifoOutValid),
    // Pop exactly when the output register loads, so no handle shows twice
    .outReady(!cpuValid)
  );
  // Fill level kept beside the buffer so ready can fall ahead of it
  reg [5:0] fill;
  wire push = wantCopy && fifoInReady;
  wire pop = fifoOutValid && !cpuValid;
  wire [5:0] next_fill = fill + {5'h00, push} - {5'h00, pop};
  wire [2:0] next_miss = rxCcm ? 3'h0 : (locTick &&
    continuity_miss_count != `MISS_MAX) ? continuity_miss_count + 3'h1 :
    continuity_miss_count; // R4 R8
  wire next_defect = (next_miss == `MISS_MAX); // R6 R9
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pduReady <= 1'b0;
      fill <= 6'h00;
      continuity_miss_count <= 3'h0;
      continuity_loss_defect <= 1'b0;
      continuity_loss_flag <= 1'b0;
      lm_insert_next_flag <= 1'b0;
      last_port_state_value <= 8'h00;
      last_if_state_value <= 8'h00;
      port_state_change_flag <= 1'b0;
      if_state_change_flag <= 1'b0;
      endTlvFlag <= 1'b0;
      periodErrorFlag <= 1'b0;
      irq <= 1'b0;
      tx_transaction_id <= 32'h00000000;
      rx_transaction_id <= 32'h00000000;
      transaction_error_flag <= 1'b0;
      test_rx_flag <= 1'b0;
      loop_request_rx_flag <= 1'b0;
      loop_reply_rx_flag <= 1'b0;
      extract_next_test_frame <= 1'b0;
      reply_rx_valid_count <= {CW{1'b0}};
      sequence_error_count <= {CW{1'b0}};
      tlv_check_fail_count <= {CW{1'b0}};
      reply_tx_count <= {CW{1'b0}};
      oamTxCount <= {CW{1'b0}};
      oamRxCount <= {CW{1'b0}};
      lossTxCount <= {CW{1'b0}};
      lossRxCount <= {CW{1'b0}};
      editValid <= 1'b0;
      editSeqWrite <= 1'b0;
      editSeq <= 32'h00000000;
      editLmInsert <= 1'b0;
      injectReply <= 1'b0;
      cpuHandle <= {FW{1'b0}};
      cpuValid <= 1'b0;
    end
    else
    begin
      // Ready falls at the edge that fills the buffer, so a back to back
      // descriptor never meets a full buffer and loses its copy
      fill <= next_fill;
      pduReady <= (next_fill != `FIFO_FULL_LEVEL); // R19
      irq <= (continuity_loss_flag && continuity_loss_irq_en) ||
        (port_state_change_flag && port_state_irq_en) ||
        (if_state_change_flag && if_state_irq_en); // R3 R7
      continuity_miss_count <= next_miss; // R4
      continuity_loss_defect <= next_defect; // R6
      // Set wins over clear on every sticky flag
      if (clearFlags)
      begin
        continuity_loss_flag <= 1'b0;
        port_state_change_flag <= 1'b0;
        if_state_change_flag <= 1'b0;
        endTlvFlag <= 1'b0;
        periodErrorFlag <= 1'b0;
        transaction_error_flag <= 1'b0;
        test_rx_flag <= 1'b0;
        loop_request_rx_flag <= 1'b0;
        loop_reply_rx_flag <= 1'b0;
      end
      if (next_defect != continuity_loss_defect)
        continuity_loss_flag <= 1'b1; // R7 R9
      if (rxv && isCcm && pduPeriod != continuity_timer_select)
        periodErrorFlag <= 1'b1; // R5
      if (rxCcm && badOrder)
        endTlvFlag <= 1'b1; // R2
      if (rxCcm && portSeen && !badOrder)
      begin
        last_port_state_value <= portVal; // R3
        if (portVal != last_port_state_value)
          port_state_change_flag <= 1'b1; // R3
      end
      if (rxCcm && ifSeen && !badOrder)
      begin
        last_if_state_value <= ifVal; // R3
        if (ifVal != last_if_state_value)
          if_state_change_flag <= 1'b1; // R3
      end
      editValid <= pduValid && pduReady;
      editSeqWrite <= 1'b0;
      editLmInsert <= 1'b0;
      editSeq <= tx_transaction_id;
      injectReply <= 1'b0;
      if (txv && isCcm && ccmHwEn && lm_insert_next_flag)
      begin
        editLmInsert <= 1'b1; // R10
        lm_insert_next_flag <= 1'b0; // R10
      end
      if (cpuSetInsertNext || lmTick)
        lm_insert_next_flag <= 1'b1; // R11
      if (txv && ((isTest && test_pdu_hw_en) || (isReq && loop_request_hw_en)))
      begin
        tx_transaction_id <= tx_transaction_id + 32'h00000001; // R16 R17
        editSeqWrite <= isTest ? test_seq_write_en :
          loop_request_seq_write_en; // R13 R16 R17
      end
      if (txv && isRep)
        reply_tx_count <= reply_tx_count + 1'b1; // R22
      if (pduValid && pduReady && !pduIsRx && seqPdu)
        oamTxCount <= bump(oamTxCount, cntEn); // R15
      if (pduValid && pduReady && pduIsRx && seqPdu)
        oamRxCount <= bump(oamRxCount, cntEn); // R15
      if (txv && seqPdu)
        lossTxCount <= bump(lossTxCount, lossEn); // R15
      if (rxv && seqPdu)
        lossRxCount <= bump(lossRxCount, lossEn); // R15
      if (rxv && isTest)
        test_rx_flag <= 1'b1; // R18
      if (rxv && isReq)
      begin
        loop_request_rx_flag <= 1'b1; // R21
        injectReply <= loop_request_hw_en && auto_reply_en; // R14 R21
      end
      if (rxv && isRep)
        loop_reply_rx_flag <= 1'b1; // R23
      if (rxv && ((isTest && test_pdu_hw_en) || (isRep && loop_reply_hw_en)))
      begin
        rx_transaction_id <= pduSeq; // R18 R23
        reply_rx_valid_count <= reply_rx_valid_count + 1'b1; // R18 R23
        if (!seqMatch)
        begin
          transaction_error_flag <= 1'b1; // R18 R23
          sequence_error_count <= sequence_error_count + 1'b1; // R18 R23
        end
        if (tlvFail)
          tlv_check_fail_count <= tlv_check_fail_count + 1'b1; // R20
      end
      if (rxv && (isTest || isRep) && extract_next_test_frame)
        extract_next_test_frame <= 1'b0; // R19
      if (setExtractNext)
        extract_next_test_frame <= 1'b1; // R19
      if (cpuValid && cpuReady)
        cpuValid <= 1'b0;
      else if (fifoOutValid && !cpuValid)
      begin
        cpuValid <= 1'b1;
        cpuHandle <= fifoOut;
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/oam_endpoint_monitor.sv
// Purpose: port checks for the OAM endpoint engine
// Assumes: one clock, rst asynchronous active high
// Notes: bound into every engine instance
`default_nettype none
module oam_endpoint_monitor #(parameter CW = 32, TW = 8, FW = 16)(
  input wire logic clock, rst, pduValid, pduReady, pduIsRx, pduOk,
  input wire logic [2:0] pduType, pduPeriod, continuity_timer_select,
  input wire logic [2:0] lm_insert_timer_select, continuity_miss_count,
  input wire logic [31:0] pduSeq, tx_transaction_id, rx_transaction_id,
  input wire logic [TW-1:0] timerExpire,
  input wire logic cpuSetInsertNext, ccmHwEn, test_pdu_hw_en,
  input wire logic loop_request_hw_en, loop_reply_hw_en, auto_reply_en,
  input wire logic continuity_loss_defect, continuity_loss_flag,
  input wire logic lm_insert_next_flag, editLmInsert, injectReply,
  input wire logic transaction_error_flag,
  input wire logic [CW-1:0] sequence_error_count, reply_tx_count
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire take = pduValid && pduReady && pduOk;
  wire tick = ccmHwEn && timerExpire[continuity_timer_select];
  wire ccmIn = take && pduIsRx && pduType == 3'h1 && ccmHwEn
    && pduPeriod == continuity_timer_select;
  wire ccmOut = take && !pduIsRx && pduType == 3'h1 && ccmHwEn;
  wire lmSet = cpuSetInsertNext || timerExpire[lm_insert_timer_select];
  wire seqIn = take && pduIsRx && (pduType == 3'h2 && test_pdu_hw_en
    || pduType == 3'h4 && loop_reply_hw_en);
  a_miss_count_up: assert property (
    tick && !ccmIn && continuity_miss_count != 3'h7
    |=> continuity_miss_count == $past(continuity_miss_count) + 3'h1)
    else $error("miss count did not step");
  a_miss_count_clear: assert property (
    ccmIn && !tick |=> continuity_miss_count == 3'h0)
    else $error("miss count not cleared");
  a_miss_count_hold: assert property (
    tick && !ccmIn && continuity_miss_count == 3'h7
    |=> continuity_miss_count == 3'h7)
    else $error("miss count wrapped");
  a_loss_flag_set: assert property (
    $changed(continuity_loss_defect) |-> ##[0:1] continuity_loss_flag)
    else $error("loss flag missing");
  a_lm_insert_use: assert property (
    ccmOut && lm_insert_next_flag && !lmSet
    |=> editLmInsert && !lm_insert_next_flag)
    else $error("insert not done");
  a_lm_insert_set: assert property (
    lmSet && !ccmOut |=> lm_insert_next_flag)
    else $error("insert flag not set");
  a_tx_id_step: assert property (
    take && !pduIsRx && (pduType == 3'h2 && test_pdu_hw_en
    || pduType == 3'h3 && loop_request_hw_en)
    |=> tx_transaction_id == $past(tx_transaction_id) + 32'h1)
    else $error("tx id did not step");
  a_rx_id_store: assert property (
    seqIn |=> rx_transaction_id == $past(pduSeq))
    else $error("rx id not stored");
  a_seq_error_count: assert property (
    seqIn && pduSeq != rx_transaction_id + 32'h1 |=> transaction_error_flag
    && sequence_error_count == $past(sequence_error_count) + 1'h1)
    else $error("sequence error missed");
  a_reply_inject: assert property (
    take && pduIsRx && pduType == 3'h3 && loop_request_hw_en
    && auto_reply_en |=> injectReply)
    else $error("no reply injected");
  a_reply_tx_count: assert property (
    take && !pduIsRx && pduType == 3'h4
    |=> reply_tx_count == $past(reply_tx_count) + 1'h1)
    else $error("reply not counted");
  c_defect: cover property ($rose(continuity_loss_defect));
  c_inject: cover property (injectReply);
  c_lm: cover property (editLmInsert);
endmodule
bind oam_endpoint_engine oam_endpoint_monitor
  #(.CW(CW), .TW(TW), .FW(FW)) mon (.*);
`default_nettype wire

// file: sim/timer_cpu_partner.sv
// Purpose: shared timer controller and CPU sink model
// Assumes: bench calls fire on its own thread
// Notes: stall stops draining, slow drains every other cycle
`default_nettype none
module timer_cpu_partner (
  input wire logic clock,
  input wire logic cpuValid,
  output logic [7:0] timerExpire,
  output logic cpuReady
);
  timeunit 1ns;
  timeprecision 100ps;
  bit stall = 0, slow = 0;
  int popped = 0;
  initial timerExpire = 8'h00;
  // Expiry is one cycle wide, as the controller emits it
  task automatic fire(input int i);
    @(negedge clock);
    timerExpire = 8'h01 << i;
    @(negedge clock);
    timerExpire = 8'h00;
  endtask
  always @(negedge clock)
    cpuReady <= !stall && (!slow || cpuReady !== 1'h1);
  always @(posedge clock)
    if (cpuValid === 1'h1 && cpuReady === 1'h1)
      popped++;
endmodule
`default_nettype wire

// file: sim/tb_oam_endpoint_engine.sv
// Purpose: self-checking bench for the OAM endpoint engine
// Assumes: partner supplies timer pulses and the CPU sink
// Notes: inputs change on the falling edge only
`default_nettype none
module tb_oam_endpoint_engine;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 0, rst = 1, pduValid = 0, pduIsRx = 0, pduOk = 1;
  logic tlvCrcGood = 1, cpuSetInsertNext = 0, setExtractNext = 0;
  logic clearFlags = 0, ccmHwEn = 1, mplsTpMode = 0, auto_reply_en = 0;
  logic test_pdu_hw_en = 0, loop_request_hw_en = 0, loop_reply_hw_en = 0;
  logic test_pdu_count_en = 1, test_loss_count_en = 1, loopCountEn = 0;
  logic loopLossCountEn = 1, test_seq_write_en = 1, test_cpu_copy_en = 0;
  logic loop_request_seq_write_en = 1, loop_request_cpu_copy_en = 0;
  logic loop_reply_cpu_copy_en = 0, test_tlv_check_en = 0;
  logic reply_tlv_check_en = 0, continuity_loss_irq_en = 1;
  logic port_state_irq_en = 1, if_state_irq_en = 1, cpuReady;
  logic [2:0] pduType = 0, pduPeriod = 2, continuity_timer_select = 2;
  logic [2:0] lm_insert_timer_select = 4, continuity_miss_count;
  logic [7:0] tlvType0 = 0, tlvValue0 = 0, tlvType1 = 0, tlvValue1 = 0;
  logic [7:0] testPattern = 0, timerExpire, last_port_state_value;
  logic [7:0] last_if_state_value;
  logic [15:0] frameHandle = 0, cpuHandle;
  logic [31:0] pduSeq = 0, tx_transaction_id, rx_transaction_id, editSeq;
  logic [31:0] reply_rx_valid_count, sequence_error_count, reply_tx_count;
  logic [31:0] tlv_check_fail_count, oamTxCount, oamRxCount, lossTxCount;
  logic [31:0] lossRxCount;
  logic pduReady, continuity_loss_defect, continuity_loss_flag, irq;
  logic lm_insert_next_flag, port_state_change_flag, if_state_change_flag;
  logic endTlvFlag, periodErrorFlag, transaction_error_flag, test_rx_flag;
  logic loop_request_rx_flag, loop_reply_rx_flag, extract_next_test_frame;
  logic editValid, editSeqWrite, editLmInsert, injectReply, cpuValid;
  int miscompares = 0, compares = 0, cyc = 0, n;
  oam_endpoint_engine uut (.*);
  timer_cpu_partner p (.clock(clock), .cpuValid(cpuValid),
    .timerExpire(timerExpire), .cpuReady(cpuReady));
  always #4 clock = ~clock;
  // Generous ceiling: the whole sequence needs a few hundred cycles
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      miscompares++;
      finish_test;
    end
  end
  task automatic finish_test;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  // Request held until the edge that samples ready high
  task automatic send(input logic rx, input logic [2:0] ty,
    input logic [31:0] sq);
    @(negedge clock);
    {pduValid, pduIsRx, pduType, pduSeq} = {1'h1, rx, ty, sq};
    @(posedge clock);
    while (pduReady !== 1'h1)
      @(posedge clock);
    @(negedge clock);
    pduValid = 1'h0;
  endtask
  task automatic pulse(ref logic s);
    @(negedge clock);
    s = 1'h1;
    @(negedge clock);
    s = 1'h0;
  endtask
  task automatic ccm(input logic [7:0] a, b, c, d);
    {tlvType0, tlvValue0, tlvType1, tlvValue1} = {a, b, c, d};
    send(1'h1, 3'h1, 32'h0);
  endtask
  task automatic t_loc;
    repeat (3) p.fire(2);
    p.fire(5);
    chk(continuity_miss_count, 3'h3);
    repeat (5) p.fire(2);
    chk(continuity_miss_count, 3'h7);
    chk(continuity_loss_defect, 1'h1);
    @(negedge clock);
    chk(irq, 1'h1);
    pulse(clearFlags);
    pduPeriod = 3'h3;
    ccm(8'h00, 8'h00, 8'h00, 8'h00);
    chk(continuity_miss_count, 3'h7);
    chk(periodErrorFlag, 1'h1);
    pduPeriod = 3'h2;
    ccm(8'h00, 8'h00, 8'h00, 8'h00);
    chk(continuity_miss_count, 3'h0);
    chk(continuity_loss_defect, 1'h0);
    chk(continuity_loss_flag, 1'h1);
    $display("t_loc end");
  endtask
  task automatic t_tlv;
    pulse(clearFlags);
    ccm(8'h02, 8'h5A, 8'h04, 8'h3C);
    chk(last_port_state_value, 8'h5A);
    chk(last_if_state_value, 8'h3C);
    chk(port_state_change_flag, 1'h1);
    ccm(8'h04, 8'h11, 8'h02, 8'h22);
    chk({last_port_state_value, last_if_state_value}, 16'h2211);
    pulse(clearFlags);
    ccm(8'h04, 8'h11, 8'h02, 8'h22);
    chk(if_state_change_flag, 1'h0);
    ccm(8'h07, 8'h01, 8'h02, 8'h77);
    chk(endTlvFlag, 1'h1);
    chk(last_port_state_value, 8'h22);
    $display("t_tlv end");
  endtask
  task automatic t_lm;
    {tlvType0, tlvType1} = 16'h0000;
    pulse(cpuSetInsertNext);
    chk(lm_insert_next_flag, 1'h1);
    send(1'h0, 3'h1, 32'h0);
    chk(lm_insert_next_flag, 1'h0);
    p.fire(4);
    chk(lm_insert_next_flag, 1'h1);
    send(1'h0, 3'h1, 32'h0);
    chk(lm_insert_next_flag, 1'h0);
    $display("t_lm end");
  endtask
  task automatic t_tx;
    test_pdu_hw_en = 1'h1;
    n = oamTxCount;
    send(1'h0, 3'h2, 32'h0);
    send(1'h0, 3'h2, 32'h0);
    chk(tx_transaction_id, 32'h2);
    chk(editSeq, 32'h1);
    chk(editSeqWrite, 1'h1);
    chk(oamTxCount, n + 2);
    {test_pdu_count_en, test_pdu_hw_en} = 2'h0;
    send(1'h0, 3'h2, 32'h0);
    chk(tx_transaction_id, 32'h2);
    chk(editSeqWrite, 1'h0);
    chk(oamTxCount, n + 2);
    {test_pdu_count_en, loop_request_hw_en} = 2'h3;
    send(1'h0, 3'h3, 32'h0);
    chk(tx_transaction_id, 32'h3);
    chk(lossTxCount, 32'h4);
    loop_request_hw_en = 1'h0;
    $display("t_tx end");
  endtask
  task automatic t_rx;
    test_pdu_hw_en = 1'h1;
    send(1'h1, 3'h2, 32'h1);
    chk(test_rx_flag, 1'h1);
    chk(transaction_error_flag, 1'h0);
    send(1'h1, 3'h2, 32'h5);
    chk(transaction_error_flag, 1'h1);
    chk(sequence_error_count, 32'h1);
    pduOk = 1'h0;
    send(1'h1, 3'h2, 32'h9);
    pduOk = 1'h1;
    chk(rx_transaction_id, 32'h5);
    {test_pdu_hw_en, loop_reply_hw_en} = 2'h1;
    send(1'h1, 3'h4, 32'h6);
    send(1'h1, 3'h4, 32'h9);
    chk(sequence_error_count, 32'h2);
    chk(reply_rx_valid_count, 32'h4);
    chk(rx_transaction_id, 32'h9);
    chk(loop_reply_rx_flag, 1'h1);
    $display("t_rx end");
  endtask
  task automatic t_crc;
    {loop_reply_hw_en, test_pdu_hw_en, test_tlv_check_en} = 3'h3;
    {tlvCrcGood, tlvType0} = {1'h0, 8'h20};
    for (int i = 1; i < 4; i++)
    begin
      testPattern = 8'(i);
      send(1'h1, 3'h2, 32'h0);
    end
    chk(tlv_check_fail_count, 32'h2);
    {test_pdu_hw_en, loop_reply_hw_en, reply_tlv_check_en} = 3'h3;
    {mplsTpMode, loop_reply_cpu_copy_en, testPattern} = {2'h3, 8'h01};
    send(1'h1, 3'h4, 32'h0);
    chk(tlv_check_fail_count, 32'h2);
    mplsTpMode = 1'h0;
    send(1'h1, 3'h4, 32'h0);
    chk(tlv_check_fail_count, 32'h3);
    tlvCrcGood = 1'h1;
    send(1'h1, 3'h4, 32'h0);
    chk(tlv_check_fail_count, 32'h3);
    $display("t_crc end");
  endtask
  task automatic t_loop;
    loop_reply_hw_en = 1'h0;
    {loop_request_hw_en, auto_reply_en, loop_request_cpu_copy_en} = 3'h7;
    loopCountEn = 1'h1;
    send(1'h1, 3'h3, 32'h0);
    chk(loop_request_rx_flag, 1'h1);
    chk(injectReply, 1'h1);
    send(1'h0, 3'h4, 32'h0);
    chk(reply_tx_count, 32'h1);
    $display("t_loop end");
  endtask
  task automatic t_fifo;
    {loop_request_hw_en, test_pdu_hw_en, test_cpu_copy_en} = 3'h3;
    {loop_request_cpu_copy_en, loop_reply_cpu_copy_en} = 2'h0;
    repeat (8) @(negedge clock);
    {p.stall, p.popped, n} = {1'h1, 32'h0, 32'h0};
    while (pduReady === 1'h1 && n < 40)
    begin
      frameHandle = 16'(n);
      send(1'h1, 3'h2, 32'h0);
      n++;
    end
    chk(n, 32'h21);
    {p.stall, p.slow} = 2'h1;
    for (int i = 0; i < 200 && p.popped < n; i++)
      @(negedge clock);
    chk(p.popped, n);
    chk(cpuValid, 1'h0);
    test_cpu_copy_en = 1'h0;
    pulse(setExtractNext);
    chk(extract_next_test_frame, 1'h1);
    send(1'h1, 3'h2, 32'h0);
    chk(extract_next_test_frame, 1'h0);
    send(1'h1, 3'h2, 32'h0);
    repeat (6) @(negedge clock);
    chk(p.popped, n + 1);
    chk(cpuHandle, 32'h20);
    $display("t_fifo end");
  endtask
  initial
  begin
    repeat (16) @(posedge clock);
    @(negedge clock);
    rst = 1'h0;
    repeat (2) @(negedge clock);
    t_loc;
    t_tlv;
    t_lm;
    t_tx;
    t_rx;
    t_crc;
    t_loop;
    t_fifo;
    finish_test;
  end
endmodule
`default_nettype wire
